// ==== pkg/sbsp_consts.vh ====
// Shared constants for the synchronous burst memory port
`ifndef SBSP_CONSTS_VH
`define SBSP_CONSTS_VH

// Array geometry: 256K words of 36 bits, viewed as 512K words of 18 bits
`define SBSP_ADDR_W        19
`define SBSP_WIDX_W        18
`define SBSP_DEPTH         262144
`define SBSP_WORD_W        36
`define SBSP_HALF_W        18
`define SBSP_LANE_W        9
`define SBSP_LANES         4

// Burst counter covers the two lowest address bits
`define SBSP_BURST_W       2

// Captured command codes
`define SBSP_OP_W          2
`define SBSP_OP_IDLE       2'h0
`define SBSP_OP_READ       2'h1
`define SBSP_OP_WRITE      2'h2
`define SBSP_OP_DESEL      2'h3

// Settings taken by a mode input left unconnected
`define SBSP_DEF_ORDER_N   1'h1
`define SBSP_DEF_MODE_N    1'h1

// Read echo buffer
`define SBSP_BUF_DEPTH     2
`define SBSP_BUF_CNT_W     2

`endif

// ==== design/sbsp_burst_counter.v ====
// Two-bit burst address counter with linear or interleaved order
`timescale 1ns/1ps
`include "sbsp_consts.vh"

module sbsp_burst_counter (
    input  wire                      clk,
    input  wire                      rst,
    input  wire                      load,
    input  wire                      advance,
    input  wire [`SBSP_BURST_W-1:0]  start_low,
    input  wire                      interleaved,
    output wire [`SBSP_BURST_W-1:0]  next_low
);
    reg  [`SBSP_BURST_W-1:0] base;
    reg  [`SBSP_BURST_W-1:0] count;
    reg  [`SBSP_BURST_W-1:0] next_count;
    reg  [`SBSP_BURST_W-1:0] next_base;

    // Load restarts the count; otherwise step only on advance
    always @* begin
        next_base  = base;
        next_count = count;
        if (load) begin
            next_base  = start_low;
            next_count = 2'h0;
        end else if (advance) begin
            next_count = count + 2'h1;           // Wraps modulo four
        end
    end

    // Linear adds the count, interleaved flips bits by it
    assign next_low = interleaved ? (next_base ^ next_count)
                                  : (next_base + next_count);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            base  <= 2'h0;
            count <= 2'h0;
        end else begin
            base  <= next_base;
            count <= next_count;
        end
    end
endmodule // sbsp_burst_counter

// ==== design/sbsp_echo_buffer.v ====
// Two-entry buffer carrying read words to a stallable receiver
`timescale 1ns/1ps
`include "sbsp_consts.vh"

module sbsp_echo_buffer (
    input  wire                       clk,
    input  wire                       rst,
    input  wire                       in_valid,
    output wire                       in_ready,
    input  wire [`SBSP_WORD_W-1:0]    in_data,
    output wire                       out_valid,
    input  wire                       out_ready,
    output wire [`SBSP_WORD_W-1:0]    out_data,
    output wire [`SBSP_BUF_CNT_W-1:0] count
);
    reg  [`SBSP_WORD_W-1:0]    slot [0:`SBSP_BUF_DEPTH-1];
    reg                        rd_ptr;
    reg                        wr_ptr;
    reg  [`SBSP_BUF_CNT_W-1:0] used;
    wire                       push;
    wire                       pop;

    assign in_ready  = (used != 2'h2);
    assign out_valid = (used != 2'h0);
    assign out_data  = slot[rd_ptr];
    assign count     = used;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Storage has no reset; only pointers and fill level do
    always @(posedge clk) begin
        if (push) begin
            slot[wr_ptr] <= in_data;
        end
    end

    // Pointer and occupancy bookkeeping
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_ptr <= 1'h0;
            wr_ptr <= 1'h0;
            used   <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            case ({push, pop})
                2'b10:   used <= used + 2'h1;
                2'b01:   used <= used - 2'h1;
                default: used <= used;
            endcase
        end
    end
endmodule // sbsp_echo_buffer

// ==== design/sbsp_port.v ====
// Synchronous burst static memory: array, burst control and data pins
`timescale 1ns/1ps
`include "sbsp_consts.vh"

// Contract
// - Organise as 512K x 18 or 256K x 36 with per-lane write selects.
// - All addresses, data, selects, strobes and writes captured on rising clock only.
// - Output enable and sleep act at once, without any clock edge.
// - Either address strobe starts a burst and loads the presented address.
// - Later burst addresses form internally, stepping only when advance is active.
// - Burst counter is two bits on the lowest address bits, four words.
// - Burst order input picks linear or interleaved stepping.
// - A fresh address every cycle is accepted unless asleep, the echo buffer is full or it holds one word with a read pending.
// - Mode input low: read data bypasses output register, same cycle.
// - Mode input high: read data registered, one extra cycle latency.
// - In pipelined mode deselect passes one fewer stage than reads, releasing drivers earlier.
// - Drivers start turning off as soon as deselect is captured.
// - Byte write stores selected lanes only while byte write enable active.
// - Global write stores every lane regardless of byte controls.
// - Writes are timed internally once captured; no pulse width needed.
// - Sleep input high or stopped clock saves power, keeping all data.
// - Unconnected mode inputs settle to a defined default.

module sbsp_port (
    input  wire                      clk,
    input  wire                      rst,
    input  wire [`SBSP_ADDR_W-1:0]   address,
    input  wire [`SBSP_WORD_W-1:0]   dq_in,
    output wire [`SBSP_WORD_W-1:0]   dq_out,
    output wire                      dq_oe,
    input  wire                      chip_select_low_n,
    input  wire                      chip_select_high,
    input  wire                      processor_addr_strobe_n,
    input  wire                      controller_addr_strobe_n,
    input  wire                      burst_advance_n,
    input  wire [`SBSP_LANES-1:0]    lane_write_select_n,
    input  wire                      lane_write_enable_n,
    input  wire                      all_lanes_write_n,
    input  wire                      output_enable_n,
    input  wire                      sleep_request,
    input  wire                      burst_order_select_n,
    input  wire                      burst_order_driven,
    input  wire                      output_mode_select_n,
    input  wire                      output_mode_driven,
    input  wire                      wide_organisation,
    output wire                      sleep_active,
    output wire                      access_ready,
    output wire                      rd_valid,
    input  wire                      rd_ready,
    output wire [`SBSP_WORD_W-1:0]   rd_data
);

    // Full-width storage; the narrow view uses half a word per address
    reg  [`SBSP_WORD_W-1:0]    mem [0:`SBSP_DEPTH-1];

    // Input-register stage
    reg  [`SBSP_ADDR_W-1:0]    addr_q;
    reg  [`SBSP_OP_W-1:0]      op_q;
    reg                        in_burst;

    // Output-register stage
    reg  [`SBSP_WORD_W-1:0]    out_reg;
    reg                        pipe_read;

    // Combinational command decode
    reg  [`SBSP_OP_W-1:0]      next_op;
    reg                        next_in_burst;
    reg                        start;
    reg                        carry_on;
    wire [`SBSP_ADDR_W-1:0]    next_addr;
    wire [`SBSP_BURST_W-1:0]   burst_next_low;
    wire                       selected;
    wire                       any_strobe;
    wire                       write_req;
    wire [`SBSP_LANES-1:0]     lanes;

    // Mode pins after their default pull
    wire                       interleaved;
    wire                       pipelined;

    // Read path and write index
    wire [`SBSP_WIDX_W-1:0]    cur_widx;
    wire [`SBSP_WIDX_W-1:0]    wr_widx;
    wire [`SBSP_WORD_W-1:0]    flow_data;
    wire                       drive;

    // Echo buffer hookup
    wire                       buf_in_ready;
    wire [`SBSP_BUF_CNT_W-1:0] buf_count;
    wire                       pending;

    // Word index in the array for either organisation
    function [`SBSP_WIDX_W-1:0] word_index;
        input [`SBSP_ADDR_W-1:0] a;
        input                    wide;
        begin
            if (wide) begin
                word_index = a[`SBSP_WIDX_W-1:0];
            end else begin
                word_index = a[`SBSP_ADDR_W-1:1];
            end
        end
    endfunction

    // Map the pin lanes onto the lanes of the stored word
    function [`SBSP_LANES-1:0] lane_map;
        input [`SBSP_LANES-1:0] pin_lanes;
        input                   wide;
        input                   upper_half;
        begin
            if (wide) begin
                lane_map = pin_lanes;
            end else if (upper_half) begin
                lane_map = {pin_lanes[1:0], 2'h0};
            end else begin
                lane_map = {2'h0, pin_lanes[1:0]};
            end
        end
    endfunction

    // Pin-side view of a stored word
    function [`SBSP_WORD_W-1:0] pin_view;
        input [`SBSP_WORD_W-1:0] word;
        input                    wide;
        input                    upper_half;
        begin
            if (wide) begin
                pin_view = word;
            end else if (upper_half) begin
                pin_view = {18'h0, word[`SBSP_WORD_W-1:`SBSP_HALF_W]};
            end else begin
                pin_view = {18'h0, word[`SBSP_HALF_W-1:0]};
            end
        end
    endfunction

    // Floating mode inputs fall back to their pulled level
    assign interleaved = burst_order_driven ? burst_order_select_n : `SBSP_DEF_ORDER_N;
    assign pipelined   = output_mode_driven ? output_mode_select_n : `SBSP_DEF_MODE_N;

    // Selection needs both enables; polarity is the controller's duty
    assign selected   = ~chip_select_low_n & chip_select_high;
    assign any_strobe = ~processor_addr_strobe_n | ~controller_addr_strobe_n;

    // Global write covers every lane; byte write needs enable and a select
    assign lanes = ~all_lanes_write_n ? {`SBSP_LANES{1'b1}}
                 : (~lane_write_enable_n ? ~lane_write_select_n
                                         : {`SBSP_LANES{1'b0}});
    assign write_req = |lanes;

    // Nothing is captured while asleep or while the echo buffer could overflow
    assign pending      = (op_q == `SBSP_OP_READ);
    assign access_ready = ~sleep_request & ((buf_count == 2'h0) | ((buf_count == 2'h1) & ~pending));

    // Decode the command presented at this edge
    always @* begin
        next_op       = `SBSP_OP_IDLE;
        next_in_burst = in_burst;
        start         = 1'b0;
        carry_on      = 1'b0;
        if (access_ready) begin
            if (any_strobe) begin
                if (selected) begin
                    // A processor strobe always opens with a read
                    start         = 1'b1;
                    next_in_burst = 1'b1;
                    if (~processor_addr_strobe_n) begin
                        next_op = `SBSP_OP_READ;
                    end else if (write_req) begin
                        next_op = `SBSP_OP_WRITE;
                    end else begin
                        next_op = `SBSP_OP_READ;
                    end
                end else begin
                    next_op       = `SBSP_OP_DESEL;
                    next_in_burst = 1'b0;
                end
            end else if (in_burst) begin
                // Continue or suspend the open burst
                carry_on = ~burst_advance_n;
                if (write_req) begin
                    next_op = `SBSP_OP_WRITE;
                end else begin
                    next_op = `SBSP_OP_READ;
                end
            end
        end
    end

    // Low address bits come from the burst counter
    sbsp_burst_counter u_counter (
        .clk         (clk),
        .rst         (rst),
        .load        (start),
        .advance     (carry_on),
        .start_low   (address[`SBSP_BURST_W-1:0]),
        .interleaved (interleaved),
        .next_low    (burst_next_low)
    );

    // A strobe takes the pins' address outright, so every cycle may restart
    assign next_addr = start ? address
                             : {addr_q[`SBSP_ADDR_W-1:`SBSP_BURST_W], burst_next_low};

    // Capture the command on the rising edge; state is reset, the array is not
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_q   <= {`SBSP_ADDR_W{1'b0}};
            op_q     <= `SBSP_OP_IDLE;
            in_burst <= 1'b0;
        end else begin
            op_q     <= next_op;
            in_burst <= next_in_burst;
            if (next_op != `SBSP_OP_IDLE) begin
                addr_q <= next_addr;
            end
        end
    end

    // Write completes on the capturing edge, so no pulse width is needed
    assign wr_widx = word_index(next_addr, wide_organisation);
    always @(posedge clk) begin : write_lanes
        reg [`SBSP_LANES-1:0] mask;
        integer               i;
        mask = lane_map(lanes, wide_organisation, next_addr[0]);
        if (next_op == `SBSP_OP_WRITE) begin
            for (i = 0; i < `SBSP_LANES; i = i + 1) begin
                if (mask[i]) begin
                    if (wide_organisation) begin
                        mem[wr_widx][i*`SBSP_LANE_W +: `SBSP_LANE_W] <=
                            dq_in[i*`SBSP_LANE_W +: `SBSP_LANE_W];
                    end else begin
                        mem[wr_widx][i*`SBSP_LANE_W +: `SBSP_LANE_W] <=
                            dq_in[(i%2)*`SBSP_LANE_W +: `SBSP_LANE_W];
                    end
                end
            end
        end
    end

    // Word at the captured address, visible right after the edge
    assign cur_widx  = word_index(addr_q, wide_organisation);
    assign flow_data = pin_view(mem[cur_widx], wide_organisation, addr_q[0]);

    // Output register stage for pipelined reads
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            out_reg   <= {`SBSP_WORD_W{1'b0}};
            pipe_read <= 1'b0;
        end else begin
            out_reg   <= flow_data;
            pipe_read <= (op_q == `SBSP_OP_READ);
        end
    end

    // Deselect in the input register cuts the drivers at once, a stage before pipelined data
    assign drive = pipelined ? (pipe_read & (op_q != `SBSP_OP_DESEL))
                             : (op_q == `SBSP_OP_READ);

    // Output enable and sleep gate the drivers with no clock involved
    assign dq_oe        = drive & ~output_enable_n & ~sleep_request;
    assign dq_out       = pipelined ? out_reg : flow_data;
    assign sleep_active = sleep_request;

    // Each read word is also echoed to a stallable receiver
    sbsp_echo_buffer u_echo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (pending),
        .in_ready  (buf_in_ready),
        .in_data   (flow_data),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (rd_data),
        .count     (buf_count)
    );

endmodule // sbsp_port

// ==== verif/sbsp_port_assertions.sv ====
// Concurrent checks on the burst memory port pins
`timescale 1ns/1ps
`include "sbsp_consts.vh"

module sbsp_port_assertions (
    input wire                     clk,
    input wire                     rst,
    input wire                     dq_oe,
    input wire                     chip_select_low_n,
    input wire                     chip_select_high,
    input wire                     processor_addr_strobe_n,
    input wire                     controller_addr_strobe_n,
    input wire [`SBSP_LANES-1:0]   lane_write_select_n,
    input wire                     lane_write_enable_n,
    input wire                     all_lanes_write_n,
    input wire                     output_enable_n,
    input wire                     sleep_request,
    input wire                     output_mode_select_n,
    input wire                     output_mode_driven,
    input wire                     sleep_active,
    input wire                     access_ready,
    input wire                     rd_valid,
    input wire                     rd_ready,
    input wire [`SBSP_WORD_W-1:0]  rd_data
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // Decode of the pins at a capturing edge; burst continuations are not visible here
    wire sel   = !chip_select_low_n && chip_select_high;
    wire stb   = !processor_addr_strobe_n || !controller_addr_strobe_n;
    wire wr    = !all_lanes_write_n || (!lane_write_enable_n && !(&lane_write_select_n));
    wire desel = access_ready && stb && !sel;
    wire rd_go = access_ready && sel && (!processor_addr_strobe_n || (!controller_addr_strobe_n && !wr));
    wire flow  = output_mode_driven && !output_mode_select_n;

    sequence s_flow_rd;
        rd_go && flow ##1 !output_enable_n && !sleep_request;
    endsequence

    // A deselect right behind the read would release the pins early
    sequence s_pipe_rd;
        rd_go && !flow ##1 !desel ##1 !output_enable_n && !sleep_request;
    endsequence

    AST_OE_OFF: assert property (output_enable_n |-> !dq_oe)
        else $error("pins driven with output enable off");
    AST_SLEEP_FLAG: assert property (sleep_active == sleep_request)
        else $error("sleep flag differs from request");
    AST_SLEEP_REFUSE: assert property (sleep_request |-> !access_ready)
        else $error("commands taken during sleep");
    AST_DESEL_OFF: assert property (desel |=> !dq_oe)
        else $error("pins still driven after deselect");
    AST_FLOW_LAT: assert property (s_flow_rd |-> dq_oe)
        else $error("flow-through read not on pins next cycle");
    AST_PIPE_LAT: assert property (s_pipe_rd |-> dq_oe)
        else $error("pipelined read not on pins after two edges");
    AST_ECHO_PUSH: assert property (rd_go |-> ##[1:2] rd_valid)
        else $error("read word not offered on echo stream");
    AST_ECHO_HOLD: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
        else $error("echo word dropped or changed while stalled");
endmodule // sbsp_port_assertions

bind sbsp_port sbsp_port_assertions u_chk (.clk, .rst, .dq_oe, .chip_select_low_n, .chip_select_high,
    .processor_addr_strobe_n, .controller_addr_strobe_n, .lane_write_select_n, .lane_write_enable_n,
    .all_lanes_write_n, .output_enable_n, .sleep_request, .output_mode_select_n, .output_mode_driven,
    .sleep_active, .access_ready, .rd_valid, .rd_ready, .rd_data);

// ==== verif/sbsp_ctrl_model.sv ====
// Bus master model driving the memory port pins
`timescale 1ns/1ps
`include "sbsp_consts.vh"

module sbsp_ctrl_model (
    input  wire                     clk,
    input  wire                     access_ready,
    output logic [`SBSP_ADDR_W-1:0] address,
    output logic [`SBSP_WORD_W-1:0] dq_in,
    output logic                    chip_select_low_n,
    output logic                    chip_select_high,
    output logic                    processor_addr_strobe_n,
    output logic                    controller_addr_strobe_n,
    output logic                    burst_advance_n,
    output logic [`SBSP_LANES-1:0]  lane_write_select_n,
    output logic                    lane_write_enable_n,
    output logic                    all_lanes_write_n
);
    // Start on a held deselect so idle edges never open a burst
    initial begin
        address = 19'h0;
        dq_in = 36'h0;
        chip_select_low_n = 1'b1;
        chip_select_high = 1'b0;
        processor_addr_strobe_n = 1'b1;
        controller_addr_strobe_n = 1'b0;
        burst_advance_n = 1'b1;
        lane_write_select_n = 4'hf;
        lane_write_enable_n = 1'b1;
        all_lanes_write_n = 1'b1;
    end

    // One bus cycle: drive after an edge, hold until an edge that finds access_ready high
    task op(input logic ps, cs, sel, burst_advance, gw, bw, input logic [3:0] ln, input logic [18:0] a,
            input logic [35:0] d);
        address <= a;
        chip_select_low_n <= ~sel;
        chip_select_high <= sel;
        processor_addr_strobe_n <= ~ps;
        controller_addr_strobe_n <= ~cs;
        burst_advance_n <= ~burst_advance;
        all_lanes_write_n <= ~gw;
        lane_write_enable_n <= ~bw;
        lane_write_select_n <= ~ln;
        dq_in <= (gw || bw) ? d : ~dq_in; // Released data flips so stale words never match
        @(negedge clk);
        while (!access_ready) begin
            @(posedge clk);
            @(negedge clk);
        end
        @(posedge clk);
    endtask
endmodule // sbsp_ctrl_model

// ==== verif/sbsp_port_bench.sv ====
// Self-checking bench for the burst memory port
`timescale 1ns/1ps
`include "sbsp_consts.vh"

module sbsp_port_bench;
    localparam logic [18:0] BASE = 19'h00040;
    logic               clk, rst, dq_oe, chip_select_low_n, chip_select_high, burst_advance_n;
    logic               processor_addr_strobe_n, controller_addr_strobe_n, lane_write_enable_n;
    logic               all_lanes_write_n, output_enable_n, sleep_request, burst_order_select_n;
    logic               burst_order_driven, output_mode_select_n, output_mode_driven, wide_organisation;
    logic               sleep_active, access_ready, rd_valid, rd_ready, stall;
    logic [3:0]         lane_write_select_n;
    logic [18:0]        address;
    logic [35:0]        dq_in, dq_out, rd_data;
    logic [35:0]        q[$];
    logic [35:0]        mem[int];
    logic [15:0]        seed;
    int                 error_cnt, checks;

    sbsp_port uut (.clk, .rst, .address, .dq_in, .dq_out, .dq_oe, .chip_select_low_n, .chip_select_high,
        .processor_addr_strobe_n, .controller_addr_strobe_n, .burst_advance_n, .lane_write_select_n,
        .lane_write_enable_n, .all_lanes_write_n, .output_enable_n, .sleep_request, .burst_order_select_n,
        .burst_order_driven, .output_mode_select_n, .output_mode_driven, .wide_organisation, .sleep_active,
        .access_ready, .rd_valid, .rd_ready, .rd_data);
    sbsp_ctrl_model u_ctrl (.clk, .access_ready, .address, .dq_in, .chip_select_low_n, .chip_select_high,
        .processor_addr_strobe_n, .controller_addr_strobe_n, .burst_advance_n, .lane_write_select_n,
        .lane_write_enable_n, .all_lanes_write_n);

    // Clock, and a watchdog at 20000 cycles, far above the few hundred cycles the run needs
    initial clk = 1'b0;
    always #12.5 clk = ~clk;
    initial begin
        #(25 * 20000);
        error_cnt++;
        finish_test();
    end

    function logic [35:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return {seed[3:0], seed, ~seed};
    endfunction

    task chk(input string nm, input logic [35:0] got, input logic [35:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task finish_test();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Receiver stalls at random but never two cycles running, unless held off on purpose
    always @(posedge clk) begin
        rd_ready <= !stall && (!rd_ready || seed[1]);
        if (!rst && rd_valid && rd_ready) begin
            if (q.size() == 0)
                chk("echo_extra", rd_data, 36'h0);
            else
                chk("echo_data", rd_data, q.pop_front());
        end
    end

    // Write through the controller strobe, updating the reference image lane by lane
    task wr(input logic [18:0] a, input logic [35:0] d, input logic gw, bw, input logic [3:0] ln);
        int w;
        w = wide_organisation ? a[17:0] : a[18:1];
        for (int l = 0; l < (wide_organisation ? 4 : 2); l++)
            if (gw || (bw && ln[l]))
                mem[w][`SBSP_LANE_W * (wide_organisation ? l : l + 2 * a[0]) +: 9] = d[`SBSP_LANE_W * l +: 9];
        u_ctrl.op(0, 1, 1, 0, gw, bw, ln, a, d);
    endtask

    task rd(input logic ps, cs, burst_advance, input logic [18:0] a, pin);
        q.push_back(mem[wide_organisation ? a[17:0] : a[18:1]]);
        u_ctrl.op(ps, cs, 1, burst_advance, 0, 0, 4'h0, pin, rnd());
    endtask

    task desel();
        u_ctrl.op(0, 1, 0, 0, 0, 0, 4'h0, 19'h0, 36'h0);
    endtask

    task reset(input logic w);
        rst <= 1'b1;
        wide_organisation <= w;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask

    task drain();
        for (int i = 0; i < 200 && q.size() > 0; i++)
            @(posedge clk);
        chk("echo_left", q.size(), 0);
    endtask

    initial begin
        error_cnt = 0;
        checks = 0;
        seed = 16'hca34;
        stall = 1'b0;
        rst = 1'b1;
        rd_ready = 1'b0;
        output_enable_n = 1'b1;
        sleep_request = 1'b0;
        burst_order_select_n = 1'b0;
        burst_order_driven = 1'b1;
        output_mode_select_n = 1'b1;
        output_mode_driven = 1'b1;
        wide_organisation = 1'b1;
        @(posedge clk);
        reset(1'b1);
        output_enable_n <= 1'b0;
        // Fresh address every cycle, then lane writes and a lane select without enable
        for (int i = 0; i < 4; i++)
            wr(BASE + i, rnd(), 1, 0, 4'h0);
        wr(BASE, rnd(), 0, 1, 4'h5);
        wr(BASE + 1, rnd(), 1, 1, 4'h1);
        q.push_back(mem[BASE + 3]);
        u_ctrl.op(0, 1, 1, 0, 0, 0, 4'hf, BASE + 3, rnd());
        for (int i = 0; i < 4; i++)
            rd(1, 0, 0, BASE + i, BASE + i);
        desel();
        // Every start offset in linear, interleaved and floating order, even offsets from the controller strobe, odd from the processor strobe
        for (int o = 0; o < 3; o++)
            for (int s = 0; s < 4; s++) begin
                burst_order_select_n <= (o != 0);
                burst_order_driven <= (o != 2);
                rd(s % 2, s % 2 == 0, 0, BASE + s, BASE + s);
                for (int n = 1; n < 4; n++)
                    rd(0, 0, 1, BASE + (o ? s ^ n : (s + n) % 4), rnd());
                rd(0, 0, 0, BASE + (o ? s ^ 3 : (s + 3) % 4), rnd());
                desel();
            end
        // Receiver held off until the buffer fills and commands are refused
        stall <= 1'b1;
        fork
            begin
                for (int i = 0; i < 4; i++)
                    rd(1, 0, 0, BASE + i, BASE + i);
                desel();
            end
            begin
                repeat (8) @(posedge clk);
                @(negedge clk);
                chk("access_ready", access_ready, 0);
                @(posedge clk);
                stall <= 1'b0;
            end
        join
        // Flow-through, pipelined and floating mode; order is floating interleaved here
        for (int m = 0; m < 3; m++) begin
            output_mode_select_n <= (m != 0);
            output_mode_driven <= (m != 2);
            desel();
            rd(1, 0, 0, BASE + 1, BASE + 1);
            fork
                begin
                    rd(0, 0, 1, BASE, rnd());
                    if (m)
                        rd(0, 0, 1, BASE + 3, rnd());
                end
                begin
                    @(negedge clk);
                    if (m) begin
                        chk("dq_oe_early", dq_oe, 0);
                        @(negedge clk);
                    end
                    chk("dq_out", dq_out, mem[BASE + 1]);
                    chk("dq_oe", dq_oe, 1);
                end
            join
            desel();
        end
        // Sleep refuses commands and keeps the array
        sleep_request <= 1'b1;
        output_enable_n <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk("sleep_active", sleep_active, 1);
        chk("sleep_ready", access_ready, 0);
        @(posedge clk);
        sleep_request <= 1'b0;
        output_enable_n <= 1'b0;
        rd(1, 0, 0, BASE + 2, BASE + 2);
        desel();
        drain();
        // Narrow halves written, then read back as one wide word
        reset(1'b0);
        wr(19'h0000a, rnd(), 1, 0, 4'h0);
        wr(19'h0000b, rnd(), 1, 0, 4'h0);
        desel();
        reset(1'b1);
        rd(1, 0, 0, 19'h00005, 19'h00005);
        desel();
        drain();
        finish_test();
    end
endmodule // sbsp_port_bench
